//--- include/gpio_expander_pkg.sv
// Shared constants and types for the 16-bit serial GPIO expander
package gpio_expander_pkg;

  // Register pointer values carried by the command byte
  localparam logic [2:0] REG_PORT0_INPUT_LEVEL  = 3'h0;
  localparam logic [2:0] REG_PORT1_INPUT_LEVEL  = 3'h1;
  localparam logic [2:0] REG_PORT0_OUTPUT_LATCH = 3'h2;
  localparam logic [2:0] REG_PORT1_OUTPUT_LATCH = 3'h3;
  localparam logic [2:0] REG_PORT0_INPUT_INVERT = 3'h4;
  localparam logic [2:0] REG_PORT1_INPUT_INVERT = 3'h5;
  localparam logic [2:0] REG_PORT0_DIRECTION    = 3'h6;
  localparam logic [2:0] REG_PORT1_DIRECTION    = 3'h7;

  // Pointer field layout: pair in bits 2:1, port in bit 0
  localparam int PTR_PORT_BIT = 0;
  localparam logic [1:0] PAIR_INPUT  = 2'h0;
  localparam logic [1:0] PAIR_OUTPUT = 2'h1;
  localparam logic [1:0] PAIR_INVERT = 2'h2;
  localparam logic [1:0] PAIR_DIR    = 2'h3;

  // Reset values
  localparam logic [7:0] OUTPUT_LATCH_RST = 8'hff;
  localparam logic [7:0] INPUT_INVERT_RST = 8'h00;
  localparam logic [7:0] DIRECTION_RST    = 8'hff;
  localparam logic [2:0] PTR_RST          = 3'h0;

  // Slave address: fixed upper nibble, default value arbitrary
  localparam logic [3:0] ADDR_FIXED_DEFAULT = 4'h4;

  // Bits per byte on the link
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Link protocol states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK,
    ST_IGNORE
  } link_state_t;

endpackage

//--- rtl/gpio_expander.sv
// Serial-bus slave 16-bit GPIO expander with change interrupt
//
// Operation
// - Input registers return live sampled pin levels
// - Writes to input registers are ignored
// - Output latch drives only output pins
// - Output register reads return the latch
// - Invert bits flip input register read data
// - Direction 1 input, 0 drives output
// - All pins are inputs after reset
// - Reset loads defaults, protocol goes idle
// - Write: address, command byte selects register
// - Write data alternates within register pair
// - Read after repeated start sends register
// - Transmit byte loaded at ack falling edge
// - Read data alternates within register pair
// - Input pin change asserts interrupt low
// - Interrupt clears on return or read
// - Interrupt clearing is tracked per port
// - Output to input switch may interrupt
// - Start and stop detected while clock high
// - Data changes while clock high are conditions
// - Acknowledge own address and every byte received after it
// - Release data line on master non-acknowledge
// - Three select pins set address low bits
// - Command byte is register pointer 0..7
`timescale 1ns/100ps

module gpio_expander
  import gpio_expander_pkg::*;
#(
  parameter logic [3:0] ADDR_FIXED = ADDR_FIXED_DEFAULT
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Serial link, open-drain data
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Address select straps
  input  wire logic       addr_sel_bit0,
  input  wire logic       addr_sel_bit1,
  input  wire logic       addr_sel_bit2,
  // Port 0 pins
  input  wire logic [7:0] port0_pin_in,
  output logic      [7:0] port0_pin_out,
  output logic      [7:0] port0_pin_oe,
  // Port 1 pins
  input  wire logic [7:0] port1_pin_in,
  output logic      [7:0] port1_pin_out,
  output logic      [7:0] port1_pin_oe,
  // Open-drain interrupt, active low
  output logic            int_n_out,
  output logic            int_n_oe
);

  // Synchroniser stages: first stage feeds only the second
  logic [1:0]      scl_sync_q, scl_sync_d;
  logic [1:0]      sda_sync_q, sda_sync_d;
  logic            scl_prev_q, scl_prev_d;
  logic            sda_prev_q, sda_prev_d;
  logic [2:0]      asel_meta_q, asel_meta_d;
  logic [2:0]      asel_q, asel_d;
  logic [1:0][7:0] pin_meta_q, pin_meta_d;
  logic [1:0][7:0] pin_q, pin_d;

  // Protocol and register state
  link_state_t     state_q, state_d;
  logic [3:0]      bit_cnt_q, bit_cnt_d;
  logic [7:0]      shift_q, shift_d;
  logic [7:0]      tx_q, tx_d;
  logic            rw_q, rw_d;
  logic [2:0]      ptr_q, ptr_d;
  logic            sda_oe_q, sda_oe_d;
  logic [1:0][7:0] out_q, out_d;
  logic [1:0][7:0] inv_q, inv_d;
  logic [1:0][7:0] dir_q, dir_d;
  logic [1:0][7:0] snap_q, snap_d;
  logic [2:0]      primed_q, primed_d;
  logic [1:0][7:0] pin_oe_q, pin_oe_d;
  logic            int_oe_q, int_oe_d;

  // Bus events from synchronised lines
  logic            scl_s, sda_s;
  logic            scl_rise, scl_fall;
  logic            start_cond, stop_cond;
  logic [1:0]      pend;
  logic [1:0]      snap_load;
  logic [6:0]      own_addr;

  // Pointer field decoders, shared by write, read and snapshot paths
  function automatic logic [1:0] ptr_pair(input logic [2:0] ptr);
    ptr_pair = ptr[2:1];
  endfunction

  function automatic logic ptr_port(input logic [2:0] ptr);
    ptr_port = ptr[PTR_PORT_BIT];
  endfunction

  // Other register of the same pair; streams alternate without limit
  function automatic logic [2:0] pair_mate(input logic [2:0] ptr);
    pair_mate = ptr ^ 3'h1;
  endfunction

  // Register read mux; input pair shows live level with inversion
  function automatic logic [7:0] read_reg(input logic [2:0] ptr,
                                          input logic [1:0][7:0] pins,
                                          input logic [1:0][7:0] outl,
                                          input logic [1:0][7:0] inv,
                                          input logic [1:0][7:0] dir);
    logic p;
    p = ptr_port(ptr);
    case (ptr_pair(ptr))
      PAIR_INPUT:  read_reg = pins[p] ^ inv[p];
      PAIR_OUTPUT: read_reg = outl[p];
      PAIR_INVERT: read_reg = inv[p];
      PAIR_DIR:    read_reg = dir[p];
      default:     read_reg = 8'h00;
    endcase
  endfunction

  // Synchroniser next values
  always_comb begin
    scl_sync_d  = {scl_sync_q[0], scl_in};
    sda_sync_d  = {sda_sync_q[0], sda_in};
    scl_prev_d  = scl_sync_q[1];
    sda_prev_d  = sda_sync_q[1];
    asel_meta_d = {addr_sel_bit2, addr_sel_bit1, addr_sel_bit0};
    asel_d      = asel_meta_q;
    pin_meta_d  = {port1_pin_in, port0_pin_in};
    pin_d       = pin_meta_q;
  end

  // Synchroniser registers; idle bus reads high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_sync_q  <= 2'h3;
      sda_sync_q  <= 2'h3;
      scl_prev_q  <= 1'h1;
      sda_prev_q  <= 1'h1;
      asel_meta_q <= 3'h0;
      asel_q      <= 3'h0;
      pin_meta_q  <= 16'h0000;
      pin_q       <= 16'h0000;
    end else begin
      scl_sync_q  <= scl_sync_d;
      sda_sync_q  <= sda_sync_d;
      scl_prev_q  <= scl_prev_d;
      sda_prev_q  <= sda_prev_d;
      asel_meta_q <= asel_meta_d;
      asel_q      <= asel_d;
      pin_meta_q  <= pin_meta_d;
      pin_q       <= pin_d;
    end
  end

  // Edge and condition detection on the second stage only
  // Edges show two to three clocks late; SCL phases must be longer than that
  assign scl_s    = scl_sync_q[1];
  assign sda_s    = sda_sync_q[1];
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  // such edges are conditions, not data
  assign start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_cond  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign own_addr = {ADDR_FIXED, asel_q};

  // only input pins raise a change
  generate
    for (genvar g = 0; g < 2; g++) begin : g_pend
      assign pend[g] = |((pin_q[g] ^ snap_q[g]) & dir_q[g]);
    end
  endgenerate

  // Protocol and register next values, snapshot load requests
  always_comb begin
    state_d   = state_q;
    bit_cnt_d = bit_cnt_q;
    shift_d   = shift_q;
    tx_d      = tx_q;
    rw_d      = rw_q;
    ptr_d     = ptr_q;
    sda_oe_d  = sda_oe_q;
    out_d     = out_q;
    inv_d     = inv_q;
    dir_d     = dir_q;
    snap_load = 2'h0;
    if (start_cond) begin
      // Repeated start keeps the pointer
      state_d   = ST_ADDR;
      bit_cnt_d = 4'h0;
      sda_oe_d  = 1'b0;
    end else if (stop_cond) begin
      state_d  = ST_IDLE;
      sda_oe_d = 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise) begin
            shift_d   = {shift_q[6:0], sda_s};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == BYTE_BITS) begin
            bit_cnt_d = 4'h0;
            sda_oe_d  = 1'b1;
            if (state_q == ST_ADDR) begin
              rw_d = shift_q[0];
              if (shift_q[7:1] == own_addr) begin
                state_d = ST_ADDR_ACK;
              end else begin
                state_d  = ST_IGNORE;
                sda_oe_d = 1'b0;
              end
            end else if (state_q == ST_CMD) begin
              ptr_d   = shift_q[2:0];
              state_d = ST_CMD_ACK;
            end else begin
              state_d = ST_WDATA_ACK;
              case (ptr_pair(ptr_q))
                PAIR_OUTPUT: out_d[ptr_port(ptr_q)] = shift_q;
                PAIR_INVERT: inv_d[ptr_port(ptr_q)] = shift_q;
                PAIR_DIR:    dir_d[ptr_port(ptr_q)] = shift_q;
                default:     ;
              endcase
              ptr_d = pair_mate(ptr_q);
            end
          end
        end
        ST_ADDR_ACK, ST_RDATA_ACK: begin
          if (state_q == ST_RDATA_ACK && scl_rise && sda_s) begin
            // master ends read with no ack
            state_d = ST_IGNORE;
          end else if (scl_fall) begin
            sda_oe_d = 1'b0;
            if (state_q == ST_ADDR_ACK && !rw_q) begin
              state_d = ST_CMD;
            end else begin
              tx_d      = read_reg(ptr_q, pin_q, out_q, inv_q, dir_q);
              sda_oe_d  = ~tx_d[7];
              state_d   = ST_RDATA;
              // reading the port clears its change
              if (ptr_pair(ptr_q) == PAIR_INPUT) begin
                snap_load[ptr_port(ptr_q)] = 1'b1;
              end
              ptr_d = pair_mate(ptr_q);
            end
          end
        end
        ST_CMD_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            state_d  = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_q == BYTE_BITS) begin
              // Release for master acknowledge slot
              bit_cnt_d = 4'h0;
              sda_oe_d  = 1'b0;
              state_d   = ST_RDATA_ACK;
            end else begin
              tx_d     = {tx_q[6:0], 1'b0};
              sda_oe_d = ~tx_d[7];
            end
          end
        end
        ST_IDLE, ST_IGNORE: begin
          sda_oe_d = 1'b0;
        end
        default: begin
          state_d  = ST_IDLE;
          sda_oe_d = 1'b0;
        end
      endcase
    end
  end

  // Protocol and register state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      rw_q      <= 1'b0;
      ptr_q     <= PTR_RST;
      sda_oe_q  <= 1'b0;
      out_q     <= {OUTPUT_LATCH_RST, OUTPUT_LATCH_RST};
      inv_q     <= {INPUT_INVERT_RST, INPUT_INVERT_RST};
      dir_q     <= {DIRECTION_RST, DIRECTION_RST};
    end else begin
      state_q   <= state_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q   <= shift_d;
      tx_q      <= tx_d;
      rw_q      <= rw_d;
      ptr_q     <= ptr_d;
      sda_oe_q  <= sda_oe_d;
      out_q     <= out_d;
      inv_q     <= inv_d;
      dir_q     <= dir_d;
    end
  end

  // Pin drivers, change snapshot and interrupt next values
  always_comb begin
    snap_d   = snap_q;
    primed_d = {primed_q[1:0], 1'b1};
    for (int g = 0; g < 2; g++) begin
      // Follow the pins until both synchroniser stages hold real levels,
      // else a false change would show just after reset
      if (!primed_q[2]) begin
        snap_d[g] = pin_q[g];
      end
      // Port read takes a fresh snapshot of that port only
      if (snap_load[g]) begin
        snap_d[g] = pin_q[g];
      end
    end
    // latch reaches only pins set as outputs
    pin_oe_d = ~dir_d;
    // any pending port pulls interrupt low
    // newly turned input compares too
    // Held off while the snapshot is being primed
    int_oe_d = primed_q[2] & (|pend);
  end

  // Pin drivers, change snapshot and interrupt state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      snap_q   <= 16'h0000;
      primed_q <= 3'h0;
      pin_oe_q <= 16'h0000;
      int_oe_q <= 1'b0;
    end else begin
      snap_q   <= snap_d;
      primed_q <= primed_d;
      pin_oe_q <= pin_oe_d;
      int_oe_q <= int_oe_d;
    end
  end

  // Open-drain lines only ever pull low
  assign sda_out       = 1'b0;
  assign sda_oe        = sda_oe_q;
  assign int_n_out     = 1'b0;
  assign int_n_oe      = int_oe_q;
  assign port0_pin_out = out_q[0];
  assign port1_pin_out = out_q[1];
  assign port0_pin_oe  = pin_oe_q[0];
  assign port1_pin_oe  = pin_oe_q[1];

endmodule // gpio_expander

//--- verification/gpio_expander_asserts.sv
// Checker for the GPIO expander ports
`timescale 1ns/100ps
module gpio_expander_asserts (
  // Clock, reset
  input logic       core_clk,
  input logic       rst,
  // Link
  input logic       scl_in,
  input logic       sda_in,
  input logic       sda_out,
  input logic       sda_oe,
  // Pins, interrupt
  input logic [7:0] port0_pin_out,
  input logic [7:0] port0_pin_oe,
  input logic [7:0] port1_pin_out,
  input logic [7:0] port1_pin_oe,
  input logic       int_n_out,
  input logic       int_n_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Defaults seen at release
  a_reset_defaults: assert property ($fell(rst) |-> !sda_oe && !int_n_oe &&
    {port1_pin_oe, port0_pin_oe} == 16'h0000 && {port1_pin_out, port0_pin_out} == 16'hffff)
    else $error("bad reset values");
  // Open drain only pulls low
  a_drain_low: assert property (!sda_out && !int_n_out)
    else $error("drain high");
  // Data moves with clock low only
  a_sda_steady: assert property (!$stable(sda_oe) |-> !scl_in)
    else $error("sda moved, clock high");
  a_ack_hold: assert property ($rose(sda_oe) |-> sda_oe [*6])
    else $error("drive too short");
  a_stop_quiet: assert property (scl_in && $rose(sda_in) |-> !sda_oe [*8])
    else $error("drive after stop");
  // Pins change after a byte, clock low
  a_dir_update: assert property (!$stable({port1_pin_oe, port0_pin_oe}) |-> !scl_in)
    else $error("dir moved, clock high");
  a_out_update: assert property (!$stable({port1_pin_out, port0_pin_out}) |-> !scl_in)
    else $error("latch moved, clock high");
  // No inputs, no interrupt
  a_outputs_quiet: assert property ((&{port1_pin_oe, port0_pin_oe}) [*4] |-> !int_n_oe)
    else $error("int with no inputs");
  // No change reported while the snapshot primes
  a_int_reset_quiet: assert property ($fell(rst) |-> !int_n_oe [*4])
    else $error("int after reset");
  cover property ($rose(sda_oe));
  cover property ($rose(int_n_oe));
  cover property ($fell(int_n_oe));
endmodule // gpio_expander_asserts

bind gpio_expander gpio_expander_asserts chk (.core_clk(core_clk), .rst(rst), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .port0_pin_out(port0_pin_out),
  .port0_pin_oe(port0_pin_oe), .port1_pin_out(port1_pin_out), .port1_pin_oe(port1_pin_oe),
  .int_n_out(int_n_out), .int_n_oe(int_n_oe));

//--- verification/gpio_expander_tb.sv
// Self-checking bench for the GPIO expander
`timescale 1ns/100ps
module gpio_expander_tb;
  import gpio_expander_pkg::*;
  logic       core_clk;
  logic       rst;
  logic [2:0] sel;
  logic [7:0] x0, x1, q, po0, po1, oe0, oe1;
  logic [7:0] rf [8];
  logic       a, sda_oe, int_oe;
  wire        scl, m_low;
  // Pull-up data line; pins show latch when driven
  wire        sda  = !(m_low || sda_oe);
  wire  [7:0] pin0 = oe0 & po0 | ~oe0 & x0;
  wire  [7:0] pin1 = oe1 & po1 | ~oe1 & x1;
  int         seed = 32'h4a3c;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  gpio_expander #(.ADDR_FIXED(ADDR_FIXED_DEFAULT)) dut (.core_clk(core_clk), .rst(rst),
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .addr_sel_bit0(sel[0]),
    .addr_sel_bit1(sel[1]), .addr_sel_bit2(sel[2]), .port0_pin_in(pin0), .port0_pin_out(po0),
    .port0_pin_oe(oe0), .port1_pin_in(pin1), .port1_pin_out(po1), .port1_pin_oe(oe1),
    .int_n_out(), .int_n_oe(int_oe));
  i2c_master_model m (.clk(core_clk), .sda(sda), .scl(scl), .sda_low(m_low));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Byte the device must acknowledge
  task automatic put(input logic [7:0] d);
    m.xfer(d, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
  endtask
  task automatic head(input logic [2:0] r);
    m.start();
    put({ADDR_FIXED_DEFAULT, sel, 1'b0});
    put({5'h00, r});
  endtask
  // Write bytes; input pair is not stored
  task automatic wr(input logic [2:0] r, input logic [7:0] d [$]);
    head(r);
    foreach (d[i]) begin
      put(d[i]);
      if (r > 3'h1)
        rf[r ^ 3'(i & 1)] = d[i];
    end
    m.stop();
  endtask
  // Expected read value from pins and shadow registers
  function automatic logic [7:0] ev(input logic [2:0] r);
    logic [7:0] lv;
    lv = (r[0] ? x1 : x0) & rf[{2'h3, r[0]}] | rf[{2'h1, r[0]}] & ~rf[{2'h3, r[0]}];
    return r[2:1] == 2'h0 ? lv ^ rf[{2'h2, r[0]}] : rf[r];
  endfunction
  task automatic rd(input logic [2:0] r, input int n);
    head(r);
    m.start();
    put({ADDR_FIXED_DEFAULT, sel, 1'b1});
    for (int i = 0; i < n; i++) begin
      m.xfer(8'hff, i == n - 1, q, a);
      chk(q, ev(r ^ 3'(i & 1)));
    end
    repeat (6) @(posedge core_clk);
    chk({7'h0, sda}, 8'h01);
    m.stop();
  endtask
  task automatic reset_all();
    rst <= 1'b1;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    rf = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
    chk(oe0 | oe1, 8'h00);
    chk({7'h0, int_oe}, 8'h00);
    for (int r = 1; r < 8; r += 2)
      rd(3'(r), 2);
  endtask
  // Interrupt level after it settles
  task automatic ichk(input logic e);
    repeat (10) @(posedge core_clk);
    chk({7'h0, int_oe}, {7'h0, e});
  endtask
  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge core_clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    sel = 3'h0;
    x0 = 8'h00;
    x1 = 8'h00;
    reset_all();
    // Random traffic, one pass slow
    for (int k = 0; k < 6; k++) begin
      m.stretch = k == 2 ? 3 : 0;
      sel <= 3'($random(seed));
      x0 <= 8'($random(seed));
      x1 <= 8'($random(seed));
      for (int r = 1; r < 8; r += 2)
        wr(3'(r), '{8'($random(seed)), 8'($random(seed)), 8'($random(seed))});
      chk(oe0, ~rf[6]);
      chk(oe1, ~rf[7]);
      chk(po0 & oe0, rf[2] & ~rf[6]);
      chk(po1 & oe1, rf[3] & ~rf[7]);
      for (int r = 1; r < 8; r += 2)
        rd(3'(r), 3);
    end
    // Foreign address is not acknowledged
    m.start();
    m.xfer({ADDR_FIXED_DEFAULT, ~sel, 1'b0}, 1'b1, q, a);
    chk({7'h0, a}, 8'h01);
    m.stop();
    wr(3'h6, '{8'hff, 8'hff});
    rd(3'h0, 2);
    ichk(1'b0);
    x0 <= x0 ^ 8'h10;
    ichk(1'b1);
    x0 <= x0 ^ 8'h10;
    ichk(1'b0);
    x0 <= x0 ^ 8'h01;
    rd(3'h1, 1);
    ichk(1'b1);
    rd(3'h0, 1);
    ichk(1'b0);
    wr(3'h6, '{8'h00, 8'h00});
    x1 <= ~x1;
    ichk(1'b0);
    wr(3'h7, '{8'hff});
    ichk(1'b1);
    reset_all();
    test_done();
  end
endmodule // gpio_expander_tb

//--- verification/i2c_master_model.sv
// Bus master model for the expander link
`timescale 1ns/100ps
module i2c_master_model (
  // Clock, resolved data
  input  logic clk,
  input  logic sda,
  // Link drive
  output logic scl,
  output logic sda_low
);
  int stretch = 0; // Slow master
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hp();
    repeat (4 + stretch) @(posedge clk);
  endtask
  task automatic start();
    hp();
    sda_low <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_low <= 1'b1;
    hp();
    scl <= 1'b0;
  endtask
  task automatic stop();
    hp();
    sda_low <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_low <= 1'b0;
    hp();
  endtask
  task automatic bit_io(input logic b, output logic r);
    repeat (2 + stretch) @(posedge clk);
    sda_low <= !b;
    repeat (2) @(posedge clk);
    scl <= 1'b1;
    hp();
    r = sda;
    scl <= 1'b0;
  endtask
  // byte MSB first, then ack bit
  task automatic xfer(input logic [7:0] d, input logic nack, output logic [7:0] q, output logic ah);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(nack, ah);
  endtask
endmodule // i2c_master_model
